// [shared/selfprog_pkg.sv]
// Purpose: Shared types and constants for the self-programming sequencer
// Assumes: One 10 MHz core clock, asynchronous active-low reset
// Notes: Core-side register map is a plain 4-bit address space
package selfprog_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_IREAD = 3'h1,
    OP_IWRITE = 3'h2,
    OP_FREAD = 3'h3,
    OP_FWRITE = 3'h4,
    OP_FERASE = 3'h5
  } op_t;
  typedef enum logic [1:0] {
    F_IDLE = 2'h0,
    F_READ = 2'h1,
    F_WRITE = 2'h2,
    F_ERASE = 2'h3
  } flash_state_t;
  typedef enum logic [1:0] {
    SEL_PTR_LO = 2'h0,
    SEL_PTR_HI = 2'h1,
    SEL_DATA_LO = 2'h2,
    SEL_DATA_HI = 2'h3
  } byte_sel_t;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int BLOCK_CYCLES = 4;
  localparam logic [1:0] BLOCK_LAST = 2'(BLOCK_CYCLES - 2);
  localparam int RAM_AW = 8;
  localparam int FLASH_AW = 10;
  localparam int BLOCK_AW = 8;
  localparam int RAM_WORDS = 1 << RAM_AW;
  localparam int FLASH_WORDS = 1 << FLASH_AW;
  localparam int RAM_SEL_BIT = 15;
  localparam logic [FLASH_AW-1:0] CFG_FIRST_WORD = 10'h3F0;
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic [WORD_W-1:0] RAM_RESET = 16'h0000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WRITE_TIME_US = 20;
  localparam int ERASE_TIME_US = 40;
  // Core register map
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h1;
  localparam logic [3:0] REG_BYTE = 4'h2;
  localparam logic [3:0] REG_ADJ = 4'h3;
  localparam logic [3:0] REG_FETCH = 4'h4;
  localparam logic [3:0] REG_SPEED = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_PTR = 4'h7;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_IRQ_STAT = 4'h9;
  localparam logic [3:0] REG_IRQ_CLR = 4'hA;
  localparam logic [3:0] REG_IRQ_EN = 4'hB;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_RAM_BIT = 3;
  localparam int CFG_FWE_BIT = 0;
  localparam int CFG_RD_LSB = 1;
  localparam int CFG_WD_LSB = 3;
  localparam int CFG_W = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h28;
  localparam int SEL_LSB = 8;
  localparam int ADJ_SUB_BIT = 8;
  localparam logic [BYTE_W-1:0] SPEED_RESET = 8'h00;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FLASH = 1;
  localparam int IRQ_REFUSED = 2;

  function automatic logic [8:0] write_divisor(input logic [3:0] code);
    unique case (code)
      4'h0: write_divisor = 9'h002;
      4'h1: write_divisor = 9'h003;
      4'h2: write_divisor = 9'h004;
      4'h3: write_divisor = 9'h006;
      4'h4: write_divisor = 9'h008;
      4'h5: write_divisor = 9'h00C;
      4'h6: write_divisor = 9'h010;
      4'h7: write_divisor = 9'h018;
      4'h8: write_divisor = 9'h020;
      4'h9: write_divisor = 9'h030;
      4'hA: write_divisor = 9'h040;
      4'hB: write_divisor = 9'h060;
      4'hC: write_divisor = 9'h080;
      4'hD: write_divisor = 9'h0C0;
      4'hE: write_divisor = 9'h100;
      4'hF: write_divisor = 9'h180;
    endcase
  endfunction
endpackage

// [shared/selfprog_if.sv]
// Purpose: Link between the core end and the program-memory sequencer
// Assumes: Both ends on clk, reset by rstn
// Notes: No clocking block; the bench joins the two ends here
`timescale 1ns/1ps
interface selfprog_if (
  input wire logic clk,
  input wire logic rstn
);
  logic op_valid;
  selfprog_pkg::op_t op;
  logic from_ram;
  logic op_accept;
  logic stall;
  logic reg_wr;
  selfprog_pkg::byte_sel_t reg_sel;
  logic [selfprog_pkg::BYTE_W-1:0] reg_wdata;
  logic adj_valid;
  logic adj_sub;
  logic [selfprog_pkg::BYTE_W-1:0] adj_amt;
  logic flash_write_enable;
  logic [1:0] flash_read_cycles_field;
  logic [3:0] flash_write_divider_field;
  logic fetch_req;
  logic fetch_ready;
  logic flash_op_pending;
  logic [selfprog_pkg::WORD_W-1:0] program_word_pointer;
  logic [selfprog_pkg::WORD_W-1:0] program_data_buffer;

  modport device_mp (
    input clk, rstn, op_valid, op, from_ram, reg_wr, reg_sel, reg_wdata,
    input adj_valid, adj_sub, adj_amt, flash_write_enable,
    input flash_read_cycles_field, flash_write_divider_field, fetch_req,
    output op_accept, stall, fetch_ready, flash_op_pending,
    output program_word_pointer, program_data_buffer
  );
  modport core_mp (
    input clk, rstn, op_accept, stall, fetch_ready, flash_op_pending,
    input program_word_pointer, program_data_buffer,
    output op_valid, op, from_ram, reg_wr, reg_sel, reg_wdata,
    output adj_valid, adj_sub, adj_amt, flash_write_enable,
    output flash_read_cycles_field, flash_write_divider_field, fetch_req
  );
endinterface

// [rtl/selfprog_device.sv]
// Purpose: Program RAM, program flash and the self-programming sequencer
// Assumes: Core end keeps its own obligations on the link
// Notes: Flash array resets to erased so a bench starts from a known image
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
module selfprog_device #(
  parameter int WRITE_TICKS = selfprog_pkg::WRITE_TIME_US,
  parameter int ERASE_TICKS = selfprog_pkg::ERASE_TIME_US
) (
  selfprog_if.device_mp sp,
  input wire logic [selfprog_pkg::WORD_W-1:0] peek_addr,
  output logic [selfprog_pkg::WORD_W-1:0] peek_data
);
  localparam logic [15:0] WRITE_LAST = 16'(WRITE_TICKS - 1);
  localparam logic [15:0] ERASE_LAST = 16'(ERASE_TICKS - 1);

  logic [selfprog_pkg::WORD_W-1:0] ram_r [selfprog_pkg::RAM_WORDS];
  logic [selfprog_pkg::WORD_W-1:0] flash_r [selfprog_pkg::FLASH_WORDS];
  logic [selfprog_pkg::WORD_W-1:0] ptr_r;
  logic [selfprog_pkg::WORD_W-1:0] data_r;
  logic blk_busy_r;
  logic [1:0] blk_cnt_r;
  selfprog_pkg::op_t blk_op_r;
  logic blk_ram_r;
  logic [selfprog_pkg::FLASH_AW-1:0] blk_idx_r;
  selfprog_pkg::flash_state_t fstate_r;
  logic [selfprog_pkg::FLASH_AW-1:0] f_idx_r;
  logic [selfprog_pkg::WORD_W-1:0] f_data_r;
  logic [1:0] rd_cnt_r;
  logic [8:0] div_cnt_r;
  logic [15:0] tick_cnt_r;
  logic [1:0] fetch_cnt_r;

  logic take;
  logic tgt_ram;
  logic [selfprog_pkg::FLASH_AW-1:0] fl_idx;
  logic in_cfg;
  logic pending;
  logic valid_blk;
  logic valid_flash;
  logic launch_blk;
  logic launch_flash;
  logic blk_end;
  logic tick;
  logic read_done;
  logic write_done;
  logic erase_done;
  logic [8:0] div_last;

  assign pending = (fstate_r != selfprog_pkg::F_IDLE);
  assign sp.flash_op_pending = pending;
  assign sp.op_accept = !blk_busy_r;
  assign sp.stall = blk_busy_r;
  assign sp.program_word_pointer = ptr_r;
  assign sp.program_data_buffer = data_r;
  assign take = sp.op_valid && sp.op_accept;
  assign tgt_ram = ptr_r[selfprog_pkg::RAM_SEL_BIT];
  assign fl_idx = ptr_r[selfprog_pkg::FLASH_AW-1:0];
  assign in_cfg = (fl_idx >= selfprog_pkg::CFG_FIRST_WORD);

  // Validity; code protection is not an input at all
  always_comb begin
    valid_blk = 1'b0;
    valid_flash = 1'b0;
    unique case (sp.op)
      selfprog_pkg::OP_IREAD: begin
        valid_blk = tgt_ram || (!in_cfg && !pending);
      end
      selfprog_pkg::OP_IWRITE: begin
        valid_blk = tgt_ram;
      end
      selfprog_pkg::OP_FREAD: begin
        valid_flash = sp.from_ram && !tgt_ram && !in_cfg && !pending;
      end
      selfprog_pkg::OP_FWRITE, selfprog_pkg::OP_FERASE: begin
        valid_flash = sp.from_ram && !tgt_ram && !in_cfg && !pending
          && sp.flash_write_enable;
      end
      default: begin
        valid_blk = 1'b0;
      end
    endcase
  end

  // Anything else is taken and dropped
  assign launch_blk = take && valid_blk;
  assign launch_flash = take && valid_flash;
  assign blk_end = blk_busy_r && (blk_cnt_r == selfprog_pkg::BLOCK_LAST);

  // Blocking operations: launch cycle plus three stall cycles
  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      blk_busy_r <= 1'b0;
      blk_cnt_r <= 2'h0;
      blk_op_r <= selfprog_pkg::OP_NONE;
      blk_ram_r <= 1'b0;
      blk_idx_r <= '0;
    end else if (launch_blk) begin
      blk_busy_r <= 1'b1;
      blk_cnt_r <= 2'h0;
      blk_op_r <= sp.op;
      blk_ram_r <= tgt_ram;
      blk_idx_r <= fl_idx;
    end else if (blk_end) begin
      blk_busy_r <= 1'b0;
    end else if (blk_busy_r) begin
      blk_cnt_r <= blk_cnt_r + 2'h1;
    end
  end

  // Pointer holds across memory operations
  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      ptr_r <= '0;
    end else if (sp.reg_wr && sp.reg_sel == selfprog_pkg::SEL_PTR_LO) begin
      ptr_r[selfprog_pkg::BYTE_W-1:0] <= sp.reg_wdata;
    end else if (sp.reg_wr && sp.reg_sel == selfprog_pkg::SEL_PTR_HI) begin
      ptr_r[selfprog_pkg::WORD_W-1:selfprog_pkg::BYTE_W] <= sp.reg_wdata;
    end else if (sp.adj_valid && sp.adj_sub) begin
      ptr_r <= ptr_r - {8'h00, sp.adj_amt};
    end else if (sp.adj_valid) begin
      ptr_r <= ptr_r + {8'h00, sp.adj_amt};
    end
  end

  // Data buffer; a memory result beats a byte write
  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      data_r <= '0;
    end else if (read_done) begin
      data_r <= flash_r[f_idx_r];
    end else if (blk_end && blk_op_r == selfprog_pkg::OP_IREAD) begin
      data_r <= blk_ram_r ? ram_r[blk_idx_r[selfprog_pkg::RAM_AW-1:0]]
        : flash_r[blk_idx_r];
    end else if (sp.reg_wr && sp.reg_sel == selfprog_pkg::SEL_DATA_LO) begin
      data_r[selfprog_pkg::BYTE_W-1:0] <= sp.reg_wdata;
    end else if (sp.reg_wr && sp.reg_sel == selfprog_pkg::SEL_DATA_HI) begin
      data_r[selfprog_pkg::WORD_W-1:selfprog_pkg::BYTE_W] <= sp.reg_wdata;
    end
  end

  // Flash sequencer timing
  assign div_last = selfprog_pkg::write_divisor(sp.flash_write_divider_field) - 9'h001;
  assign tick = (div_cnt_r == div_last);
  assign read_done = (fstate_r == selfprog_pkg::F_READ)
    && (rd_cnt_r == sp.flash_read_cycles_field);
  assign write_done = (fstate_r == selfprog_pkg::F_WRITE) && tick
    && (tick_cnt_r == WRITE_LAST);
  assign erase_done = (fstate_r == selfprog_pkg::F_ERASE) && tick
    && (tick_cnt_r == ERASE_LAST);

  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      fstate_r <= selfprog_pkg::F_IDLE;
      f_idx_r <= '0;
      f_data_r <= '0;
    end else if (launch_flash) begin
      f_idx_r <= fl_idx;
      f_data_r <= data_r;
      unique case (sp.op)
        selfprog_pkg::OP_FREAD: fstate_r <= selfprog_pkg::F_READ;
        selfprog_pkg::OP_FWRITE: fstate_r <= selfprog_pkg::F_WRITE;
        default: fstate_r <= selfprog_pkg::F_ERASE;
      endcase
    end else if (read_done || write_done || erase_done) begin
      fstate_r <= selfprog_pkg::F_IDLE;
    end
  end

  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      rd_cnt_r <= 2'h0;
      div_cnt_r <= 9'h000;
      tick_cnt_r <= 16'h0000;
    end else if (launch_flash) begin
      rd_cnt_r <= 2'h0;
      div_cnt_r <= 9'h000;
      tick_cnt_r <= 16'h0000;
    end else if (fstate_r == selfprog_pkg::F_READ) begin
      rd_cnt_r <= rd_cnt_r + 2'h1;
    end else if (pending && tick) begin
      div_cnt_r <= 9'h000;
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end else if (pending) begin
      div_cnt_r <= div_cnt_r + 9'h001;
    end
  end

  // Fetch throttle: flash fetch waits out the read access time
  assign sp.fetch_ready = sp.fetch_req && !pending
    && (fetch_cnt_r == sp.flash_read_cycles_field);

  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      fetch_cnt_r <= 2'h0;
    end else if (sp.fetch_req && !sp.fetch_ready && !pending) begin
      fetch_cnt_r <= fetch_cnt_r + 2'h1;
    end else begin
      fetch_cnt_r <= 2'h0;
    end
  end

  // Storage, one flop word per entry
  for (genvar g = 0; g < selfprog_pkg::RAM_WORDS; g++) begin : g_ram
    localparam logic [selfprog_pkg::RAM_AW-1:0] IDX = selfprog_pkg::RAM_AW'(g);
    always_ff @(posedge sp.clk or negedge sp.rstn) begin
      if (!sp.rstn) begin
        ram_r[g] <= selfprog_pkg::RAM_RESET;
      end else if (blk_end && blk_op_r == selfprog_pkg::OP_IWRITE
          && blk_idx_r[selfprog_pkg::RAM_AW-1:0] == IDX) begin
        ram_r[g] <= data_r;
      end
    end
  end

  for (genvar g = 0; g < selfprog_pkg::FLASH_WORDS; g++) begin : g_flash
    localparam logic [selfprog_pkg::FLASH_AW-1:0] IDX = selfprog_pkg::FLASH_AW'(g);
    localparam logic CFG = (IDX >= selfprog_pkg::CFG_FIRST_WORD);
    always_ff @(posedge sp.clk or negedge sp.rstn) begin
      if (!sp.rstn) begin
        flash_r[g] <= selfprog_pkg::ERASED_WORD;
      end else if (erase_done && !CFG
          && f_idx_r[selfprog_pkg::FLASH_AW-1:selfprog_pkg::BLOCK_AW]
          == IDX[selfprog_pkg::FLASH_AW-1:selfprog_pkg::BLOCK_AW]) begin
        flash_r[g] <= selfprog_pkg::ERASED_WORD;
      end else if (write_done && f_idx_r == IDX) begin
        flash_r[g] <= flash_r[g] & f_data_r;
      end
    end
  end

  // Debug view of either memory
  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      peek_data <= '0;
    end else if (peek_addr[selfprog_pkg::RAM_SEL_BIT]) begin
      peek_data <= ram_r[peek_addr[selfprog_pkg::RAM_AW-1:0]];
    end else begin
      peek_data <= flash_r[peek_addr[selfprog_pkg::FLASH_AW-1:0]];
    end
  end
endmodule // selfprog_device

// [rtl/selfprog_core.sv]
// Purpose: Core end issuing self-programming operations from registers
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: Refuses flash operations that software may not issue
`timescale 1ns/1ps
module selfprog_core (
  selfprog_if.core_mp sp,
  input wire logic [3:0] reg_addr,
  input wire logic [selfprog_pkg::WORD_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [selfprog_pkg::WORD_W-1:0] reg_rdata,
  output logic irq,
  output logic [selfprog_pkg::BYTE_W-1:0] core_speed
);
  logic cmd_valid_r;
  selfprog_pkg::op_t cmd_op_r;
  logic cmd_ram_r;
  logic [selfprog_pkg::CFG_W-1:0] cfg_r;
  logic bwr_r;
  selfprog_pkg::byte_sel_t bsel_r;
  logic [selfprog_pkg::BYTE_W-1:0] bdat_r;
  logic adj_r;
  logic adj_sub_r;
  logic [selfprog_pkg::BYTE_W-1:0] adj_amt_r;
  logic fetch_want_r;
  logic [selfprog_pkg::BYTE_W-1:0] speed_req_r;
  logic speed_wait_r;
  logic pend_d_r;
  logic [selfprog_pkg::IRQ_W-1:0] irq_stat_r;
  logic [selfprog_pkg::IRQ_W-1:0] irq_en_r;
  logic [2:0] wop;
  logic wr_cmd;
  logic flash_op;
  logic refuse;
  logic [selfprog_pkg::IRQ_W-1:0] events;

  assign wop = reg_wdata[selfprog_pkg::CMD_OP_LSB +: 3];
  assign wr_cmd = reg_wr && reg_addr == selfprog_pkg::REG_CMD;
  assign flash_op = wop >= selfprog_pkg::OP_FREAD;
  // Flash ops only from RAM, and only once the last one ended
  assign refuse = (wr_cmd && (cmd_valid_r || wop > selfprog_pkg::OP_FERASE
      || (flash_op && (!reg_wdata[selfprog_pkg::CMD_RAM_BIT]
      || sp.flash_op_pending))))
    || (reg_wr && reg_addr == selfprog_pkg::REG_CFG && sp.flash_op_pending);

  assign sp.op_valid = cmd_valid_r;
  assign sp.op = cmd_op_r;
  assign sp.from_ram = cmd_ram_r;
  assign sp.reg_wr = bwr_r;
  assign sp.reg_sel = bsel_r;
  assign sp.reg_wdata = bdat_r;
  assign sp.adj_valid = adj_r;
  assign sp.adj_sub = adj_sub_r;
  assign sp.adj_amt = adj_amt_r;
  assign sp.flash_write_enable = cfg_r[selfprog_pkg::CFG_FWE_BIT];
  assign sp.flash_read_cycles_field = cfg_r[selfprog_pkg::CFG_RD_LSB +: 2];
  assign sp.flash_write_divider_field = cfg_r[selfprog_pkg::CFG_WD_LSB +: 4];
  assign sp.fetch_req = fetch_want_r && !sp.flash_op_pending;

  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      cmd_valid_r <= 1'b0;
      cmd_op_r <= selfprog_pkg::OP_NONE;
      cmd_ram_r <= 1'b0;
    end else if (cmd_valid_r && sp.op_accept) begin
      cmd_valid_r <= 1'b0;
    end else if (wr_cmd && !refuse && wop != selfprog_pkg::OP_NONE) begin
      cmd_valid_r <= 1'b1;
      cmd_op_r <= selfprog_pkg::op_t'(wop);
      cmd_ram_r <= reg_wdata[selfprog_pkg::CMD_RAM_BIT];
    end
  end

  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      cfg_r <= selfprog_pkg::CFG_RESET;
    end else if (reg_wr && reg_addr == selfprog_pkg::REG_CFG && !refuse) begin
      cfg_r <= reg_wdata[selfprog_pkg::CFG_W-1:0];
    end
  end

  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      bwr_r <= 1'b0;
      bsel_r <= selfprog_pkg::SEL_PTR_LO;
      bdat_r <= '0;
      adj_r <= 1'b0;
      adj_sub_r <= 1'b0;
      adj_amt_r <= '0;
    end else begin
      bwr_r <= reg_wr && reg_addr == selfprog_pkg::REG_BYTE;
      bsel_r <= selfprog_pkg::byte_sel_t'(reg_wdata[selfprog_pkg::SEL_LSB +: 2]);
      bdat_r <= reg_wdata[selfprog_pkg::BYTE_W-1:0];
      adj_r <= reg_wr && reg_addr == selfprog_pkg::REG_ADJ;
      adj_sub_r <= reg_wdata[selfprog_pkg::ADJ_SUB_BIT];
      adj_amt_r <= reg_wdata[selfprog_pkg::BYTE_W-1:0];
    end
  end

  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      fetch_want_r <= 1'b0;
    end else if (reg_wr && reg_addr == selfprog_pkg::REG_FETCH) begin
      fetch_want_r <= 1'b1;
    end else if (sp.fetch_ready) begin
      fetch_want_r <= 1'b0;
    end
  end

  // Speed change waits for the flash operation to end
  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      speed_req_r <= selfprog_pkg::SPEED_RESET;
      speed_wait_r <= 1'b0;
      core_speed <= selfprog_pkg::SPEED_RESET;
    end else if (reg_wr && reg_addr == selfprog_pkg::REG_SPEED) begin
      speed_req_r <= reg_wdata[selfprog_pkg::BYTE_W-1:0];
      speed_wait_r <= 1'b1;
    end else if (speed_wait_r && !sp.flash_op_pending) begin
      core_speed <= speed_req_r;
      speed_wait_r <= 1'b0;
    end
  end

  assign events[selfprog_pkg::IRQ_DONE] = cmd_valid_r && sp.op_accept;
  assign events[selfprog_pkg::IRQ_FLASH] = pend_d_r && !sp.flash_op_pending;
  assign events[selfprog_pkg::IRQ_REFUSED] = refuse;

  // Sticky status; a new event beats a clear
  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      pend_d_r <= 1'b0;
      irq_stat_r <= '0;
      irq_en_r <= '0;
    end else begin
      pend_d_r <= sp.flash_op_pending;
      if (reg_wr && reg_addr == selfprog_pkg::REG_IRQ_CLR) begin
        irq_stat_r <= (irq_stat_r & ~reg_wdata[selfprog_pkg::IRQ_W-1:0]) | events;
      end else begin
        irq_stat_r <= irq_stat_r | events;
      end
      if (reg_wr && reg_addr == selfprog_pkg::REG_IRQ_EN) begin
        irq_en_r <= reg_wdata[selfprog_pkg::IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  always_ff @(posedge sp.clk or negedge sp.rstn) begin
    if (!sp.rstn) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        selfprog_pkg::REG_STATUS: reg_rdata <= {11'h000, fetch_want_r,
          speed_wait_r, cmd_valid_r, sp.stall, sp.flash_op_pending};
        selfprog_pkg::REG_PTR: reg_rdata <= sp.program_word_pointer;
        selfprog_pkg::REG_DATA: reg_rdata <= sp.program_data_buffer;
        selfprog_pkg::REG_CFG: reg_rdata <= {9'h000, cfg_r};
        selfprog_pkg::REG_SPEED: reg_rdata <= {8'h00, core_speed};
        selfprog_pkg::REG_IRQ_STAT: reg_rdata <= {13'h0000, irq_stat_r};
        selfprog_pkg::REG_IRQ_EN: reg_rdata <= {13'h0000, irq_en_r};
        default: reg_rdata <= '0;
      endcase
    end
  end
endmodule // selfprog_core

// [verif/selfprog_monitor.sv]
// Purpose: Link checks between core end and sequencer
// Assumes: One clock, rstn async active low
// Notes: Sees link signals only
`timescale 1ns/1ps
module selfprog_monitor (
  input logic clk,
  input logic rstn,
  input logic op_valid,
  input selfprog_pkg::op_t op,
  input logic from_ram,
  input logic op_accept,
  input logic stall,
  input logic reg_wr,
  input logic adj_valid,
  input logic adj_sub,
  input logic [7:0] adj_amt,
  input logic flash_write_enable,
  input logic [1:0] flash_read_cycles_field,
  input logic fetch_req,
  input logic fetch_ready,
  input logic flash_op_pending,
  input logic [15:0] program_word_pointer,
  input logic [15:0] program_data_buffer
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic tk;
  assign tk = op_valid && op_accept && !flash_op_pending;
  property p_acc; $rose(stall) |-> $past(op_valid && op_accept); endproperty
  a_acc: assert property (p_acc) else $error("stall rose without a take");
  property p_blk; tk && op inside {selfprog_pkg::OP_IREAD, selfprog_pkg::OP_IWRITE}
    && program_word_pointer[15] |=> stall [*3] ##1 !stall; endproperty
  a_blk: assert property (p_blk) else $error("blocking op length wrong");
  property p_frd; tk && op == selfprog_pkg::OP_FREAD && from_ram && flash_write_enable == 1'b0
    && program_word_pointer < 16'h03F0 && flash_read_cycles_field == 2'h0
    |=> flash_op_pending ##1 !flash_op_pending; endproperty
  a_frd: assert property (p_frd) else $error("flash read pending wrong");
  property p_fwe; tk && op inside {selfprog_pkg::OP_FWRITE, selfprog_pkg::OP_FERASE}
    && !flash_write_enable |=> !flash_op_pending; endproperty
  a_fwe: assert property (p_fwe) else $error("write with enable low ran");
  property p_hold; !reg_wr && !adj_valid |=> $stable(program_word_pointer); endproperty
  a_hold: assert property (p_hold) else $error("pointer moved");
  property p_adj; adj_valid && !reg_wr |=> program_word_pointer == ($past(adj_sub) ?
    $past(program_word_pointer) - 16'($past(adj_amt)) :
    $past(program_word_pointer) + 16'($past(adj_amt))); endproperty
  a_adj: assert property (p_adj) else $error("pointer adjust wrong");
  property p_buf; !reg_wr && !stall && !flash_op_pending |=> $stable(program_data_buffer);
  endproperty
  a_buf: assert property (p_buf) else $error("buffer changed");
  property p_fet; fetch_ready |-> fetch_req && !flash_op_pending; endproperty
  a_fet: assert property (p_fet) else $error("fetch during pending");
  c_frd: cover property (tk && op == selfprog_pkg::OP_FREAD);
  c_stl: cover property (stall);
  c_fet: cover property (fetch_ready);
endmodule // selfprog_monitor

// [verif/tb_program_memory_self_programming.sv]
// Purpose: Bench for both ends of the self-programming link
// Assumes: Core register port drives all traffic
// Notes: Short write and erase ticks keep the run brief
`timescale 1ns/1ps
module tb_program_memory_self_programming;
  logic clk, rstn, reg_wr, reg_rd, irq;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, peek_addr, peek_data, s;
  logic [7:0] spd;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  selfprog_if sp (.clk(clk), .rstn(rstn));
  selfprog_core i_selfprog_core (.sp(sp.core_mp), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .core_speed(spd));
  selfprog_device #(.WRITE_TICKS(2), .ERASE_TICKS(3)) i_selfprog_device (.sp(sp.device_mp),
    .peek_addr(peek_addr), .peek_data(peek_data));
  selfprog_monitor i_selfprog_monitor (.clk(clk), .rstn(rstn), .op_valid(sp.op_valid),
    .op(sp.op), .from_ram(sp.from_ram), .op_accept(sp.op_accept), .stall(sp.stall),
    .reg_wr(sp.reg_wr), .adj_valid(sp.adj_valid), .adj_sub(sp.adj_sub), .adj_amt(sp.adj_amt),
    .flash_write_enable(sp.flash_write_enable),
    .flash_read_cycles_field(sp.flash_read_cycles_field), .fetch_req(sp.fetch_req),
    .fetch_ready(sp.fetch_ready), .flash_op_pending(sp.flash_op_pending),
    .program_word_pointer(sp.program_word_pointer),
    .program_data_buffer(sp.program_data_buffer));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    repeat (2) @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input string n, input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(n, v, exp);
  endtask
  task automatic pk(input string n, input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    peek_addr <= a;
    repeat (2) @(posedge clk);
    #1 chk(n, peek_data, exp);
  endtask
  task automatic idle();
    logic [15:0] v;
    v = 16'h0007;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 100 && v[2:0] != 3'h0; i++) rd(selfprog_pkg::REG_STATUS, v);
    chk("idle", {13'h0000, v[2:0]}, 16'h0000);
  endtask
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    peek_addr = 16'h0000;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rc("cfg", selfprog_pkg::REG_CFG, 16'h0028);
    rc("status", selfprog_pkg::REG_STATUS, 16'h0000);
    rc("unmapped", 4'hF, 16'h0000);
    wr(selfprog_pkg::REG_BYTE, 16'h00FF);
    wr(selfprog_pkg::REG_BYTE, 16'h0180);
    wr(selfprog_pkg::REG_ADJ, 16'h0001);
    rc("ptr_inc", selfprog_pkg::REG_PTR, 16'h8100);
    wr(selfprog_pkg::REG_ADJ, 16'h0101);
    rc("ptr_dec", selfprog_pkg::REG_PTR, 16'h80FF);
    wr(selfprog_pkg::REG_BYTE, 16'h0234);
    wr(selfprog_pkg::REG_BYTE, 16'h0312);
    wr(selfprog_pkg::REG_CMD, 16'h000A);
    idle();
    pk("ram", 16'h80FF, 16'h1234);
    rc("ptr_kept", selfprog_pkg::REG_PTR, 16'h80FF);
    wr(selfprog_pkg::REG_BYTE, 16'h0200);
    wr(selfprog_pkg::REG_BYTE, 16'h0300);
    wr(selfprog_pkg::REG_CMD, 16'h0009);
    idle();
    rc("iread", selfprog_pkg::REG_DATA, 16'h1234);
    wr(selfprog_pkg::REG_BYTE, 16'h0005);
    wr(selfprog_pkg::REG_BYTE, 16'h0100);
    wr(selfprog_pkg::REG_CMD, 16'h000B);
    wr(selfprog_pkg::REG_FETCH, 16'h0001);
    idle();
    rc("fread", selfprog_pkg::REG_DATA, 16'hFFFF);
    wr(selfprog_pkg::REG_BYTE, 16'h0234);
    wr(selfprog_pkg::REG_BYTE, 16'h0312);
    wr(selfprog_pkg::REG_CMD, 16'h000C);
    idle();
    pk("fwe_off", 16'h0005, 16'hFFFF);
    wr(selfprog_pkg::REG_CMD, 16'h0004);
    rd(selfprog_pkg::REG_IRQ_STAT, s);
    chk("refused", s & 16'h0004, 16'h0004);
    chk("irq_masked", {15'h0000, irq}, 16'h0000);
    wr(selfprog_pkg::REG_IRQ_EN, 16'h0007);
    #1 chk("irq_on", {15'h0000, irq}, 16'h0001);
    wr(selfprog_pkg::REG_IRQ_CLR, 16'h0007);
    rc("irq_clr", selfprog_pkg::REG_IRQ_STAT, 16'h0000);
    chk("irq_off", {15'h0000, irq}, 16'h0000);
    wr(selfprog_pkg::REG_CFG, 16'h0029);
    wr(selfprog_pkg::REG_CMD, 16'h000C);
    wr(selfprog_pkg::REG_SPEED, 16'h0042);
    wr(selfprog_pkg::REG_FETCH, 16'h0001);
    wr(selfprog_pkg::REG_CFG, 16'h0000);
    rc("busy", selfprog_pkg::REG_STATUS, 16'h0019);
    chk("speed_held", {8'h00, spd}, 16'h0000);
    idle();
    rc("cfg_kept", selfprog_pkg::REG_CFG, 16'h0029);
    rc("speed", selfprog_pkg::REG_SPEED, 16'h0042);
    chk("core_speed", {8'h00, spd}, 16'h0042);
    rc("settled", selfprog_pkg::REG_STATUS, 16'h0000);
    pk("fwrite", 16'h0005, 16'h1234);
    wr(selfprog_pkg::REG_CMD, 16'h000D);
    idle();
    pk("erase", 16'h0005, 16'hFFFF);
    wr(selfprog_pkg::REG_BYTE, 16'h00F0);
    wr(selfprog_pkg::REG_BYTE, 16'h0103);
    wr(selfprog_pkg::REG_CMD, 16'h000C);
    idle();
    pk("cfg_word", 16'h03F0, 16'hFFFF);
    tally_and_finish();
  end
endmodule // tb_program_memory_self_programming
